// ---- hw/cms_pkg.sv ----
/*
  shared constants and types of the clock manager static configuration block.
  assumes a 32-bit classic wishbone slave at byte addresses.
*/
package cms_pkg;
  // phase-shift modes
  typedef enum logic [2:0] {
    CMS_NONE, CMS_FIXED, CMS_VARPOS, CMS_VARCTR, CMS_DIRECT
  } cms_shift_e;
  typedef enum logic {CMS_SYS_SYNC, CMS_SRC_SYNC} cms_deskew_e;
  typedef enum logic {CMS_LOW, CMS_HIGH} cms_band_e;
  typedef enum logic {CMS_MAX_SPEED, CMS_MAX_RANGE} cms_goal_e;
  typedef logic signed [10:0] cms_phase_t;
  // wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cms_wbreq_s;
  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_RATIO = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // field positions
  localparam int CFG_HALVE = 3;
  localparam int CFG_DESKEW = 4;
  localparam int CFG_SBAND = 5;
  localparam int CFG_LBAND = 6;
  localparam int CFG_DUTY = 7;
  localparam int CFG_GOAL = 8;
  localparam int CFG_HOLD = 9;
  localparam int CFG_LPH = 10;
  localparam int CFG_JIT = 16;
  localparam int RAT_M = 8;
  localparam int RAT_D = 16;
  localparam int PH_INC = 0;
  localparam int PH_DEC = 1;
  localparam int ST_LOCK = 0;
  localparam int ST_STALL = 1;
  localparam int ST_PER = 16;
  ////////////////////////////////////////////////////////////////////////
  // defaults and ranges
  localparam int PHASE_DEF = 0;
  localparam int PHASE_MIN = -255;
  localparam int PHASE_VMAX = 255;
  localparam int PHASE_DMAX = 1023;
  localparam int RATIO2_DEF = 4;
  localparam int RATIO2_MIN = 3;
  localparam int RATIO2_HALF_MAX = 15;
  localparam int RATIO2_MAX = 32;
  localparam int SYNTH_M_DEF = 4;
  localparam int SYNTH_M_MIN = 2;
  localparam int SYNTH_M_MAX = 32;
  localparam int SYNTH_D_DEF = 1;
  localparam int SYNTH_D_MIN = 1;
  localparam int SYNTH_D_MAX = 32;
  localparam logic [15:0] JITTER_DEF = 16'hF0F0;
  localparam int LOCK_NOWAIT = 7;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;
endpackage : cms_pkg

// ---- hw/cms_static_config.sv ----
/*
  clock manager static configuration: elaboration-time settings, a divided
  clock, a synthesized clock, four phase outputs, phase offset stepping over
  wishbone and the lock-wait stall toward the startup sequencer.
  assumes refClkIn and lockIn are asynchronous pins, startupCycle is on clk.
*/
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - phase offset is start point in variable modes
// - variable-positive offset limited to 0..255
// - centered or fixed offset limited -255..255
// - direct offset limited to 0..1023
// - offset integer span -255..1023, default 0
// - stall chosen startup cycle until locked
// - divided clock is reference over N
// - divided clock 50/50 per band rules
// - halving divides reference by two first
// - five shift modes, default none
// - feedback delay system or source synchronous
// - synthesizer band low or high, default low
// - loop band low or high, default low
// - duty correction gives 50/50 phase outputs
// - goal speed or range, default speed
// - synthesized clock is reference times M/D
// - phase step is 1/256 reference period
// - jitter filter word defaults 0xF0F0
module cms_static_config #(
  parameter cms_pkg::cms_shift_e SHIFT_MODE = cms_pkg::CMS_NONE,
  parameter int PHASE_SHIFT = cms_pkg::PHASE_DEF,
  parameter int RATIO2 = cms_pkg::RATIO2_DEF,
  parameter int SYNTH_M = cms_pkg::SYNTH_M_DEF,
  parameter int SYNTH_D = cms_pkg::SYNTH_D_DEF,
  parameter bit HALVE = 1'b0,
  parameter cms_pkg::cms_deskew_e DESKEW = cms_pkg::CMS_SYS_SYNC,
  parameter cms_pkg::cms_band_e SYNTH_BAND = cms_pkg::CMS_LOW,
  parameter cms_pkg::cms_band_e LOOP_BAND = cms_pkg::CMS_LOW,
  parameter bit DUTY_CORR = 1'b1,
  parameter cms_pkg::cms_goal_e GOAL = cms_pkg::CMS_MAX_SPEED,
  parameter logic [15:0] JITTER_WORD = cms_pkg::JITTER_DEF,
  parameter bit HOLD_BOOT = 1'b0,
  parameter logic [2:0] LOCK_PHASE = 3'(cms_pkg::LOCK_NOWAIT)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire cms_pkg::cms_wbreq_s wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  input wire logic refClkIn,
  input wire logic lockIn,
  input wire logic [2:0] startupCycle,
  output logic bootStall,
  output logic divClkOut,
  output logic synthClkOut,
  output logic synthClkInv,
  output logic phaseOut000,
  output logic phaseOut090,
  output logic phaseOut180,
  output logic phaseOut270
);
  function automatic int phaseLo(cms_pkg::cms_shift_e m);
    phaseLo = (m == cms_pkg::CMS_FIXED || m == cms_pkg::CMS_VARCTR) ? cms_pkg::PHASE_MIN : 0;
  endfunction : phaseLo
  function automatic int phaseHi(cms_pkg::cms_shift_e m);
    phaseHi = (m == cms_pkg::CMS_DIRECT) ? cms_pkg::PHASE_DMAX : cms_pkg::PHASE_VMAX;
  endfunction : phaseHi
  localparam cms_pkg::cms_phase_t LO = 11'(phaseLo(SHIFT_MODE));
  localparam cms_pkg::cms_phase_t HI = 11'(phaseHi(SHIFT_MODE));
  localparam cms_pkg::cms_phase_t START =
    (SHIFT_MODE == cms_pkg::CMS_DIRECT || SHIFT_MODE == cms_pkg::CMS_NONE) ?
    11'sh000 : 11'(PHASE_SHIFT);
  localparam bit STEPS = SHIFT_MODE == cms_pkg::CMS_VARPOS ||
    SHIFT_MODE == cms_pkg::CMS_VARCTR || SHIFT_MODE == cms_pkg::CMS_DIRECT;
  localparam logic [5:0] R = 6'(RATIO2);
  localparam logic [5:0] M2 = 6'(SYNTH_M);
  localparam logic [5:0] D = 6'(SYNTH_D);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (PHASE_SHIFT < cms_pkg::PHASE_MIN || PHASE_SHIFT > cms_pkg::PHASE_DMAX) begin : badSpan
    $error("phase offset outside overall span");
  end
  if (SHIFT_MODE != cms_pkg::CMS_NONE && SHIFT_MODE != cms_pkg::CMS_DIRECT &&
      (PHASE_SHIFT < phaseLo(SHIFT_MODE) || PHASE_SHIFT > phaseHi(SHIFT_MODE))) begin : badPh
    $error("phase offset outside mode range");
  end
  if (SHIFT_MODE == cms_pkg::CMS_DIRECT &&
      (PHASE_SHIFT < 0 || PHASE_SHIFT > cms_pkg::PHASE_DMAX)) begin : badDir
    $error("direct phase offset outside range");
  end
  if (RATIO2 < cms_pkg::RATIO2_MIN || RATIO2 > cms_pkg::RATIO2_MAX ||
      (RATIO2 > cms_pkg::RATIO2_HALF_MAX && RATIO2 % 2 != 0)) begin : badDv
    $error("divided clock ratio not allowed");
  end
  if (SYNTH_M < cms_pkg::SYNTH_M_MIN || SYNTH_M > cms_pkg::SYNTH_M_MAX ||
      SYNTH_D < cms_pkg::SYNTH_D_MIN || SYNTH_D > cms_pkg::SYNTH_D_MAX) begin : badFx
    $error("synthesizer factors out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] refSync;
  logic [2:0] lockSync;
  logic refLvl;
  logic lockLvl;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refSync <= 3'h0;
      lockSync <= 3'h0;
      refLvl <= 1'b0;
      lockLvl <= 1'b0;
    end else begin
      refSync <= {refSync[1:0], refClkIn};
      lockSync <= {lockSync[1:0], lockIn};
      if (refSync[1] == refSync[2]) refLvl <= refSync[2];
      if (lockSync[1] == lockSync[2]) lockLvl <= lockSync[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // effective reference and period measure
  logic refPrev;
  logic halfRef;
  logic effPrev;
  logic [15:0] cnt;
  logic [15:0] period;
  wire effRef = HALVE ? halfRef : refLvl;
  wire effRise = effRef && !effPrev;
  wire effEdge = effRef != effPrev;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refPrev <= 1'b0;
      halfRef <= 1'b0;
      effPrev <= 1'b0;
      cnt <= 16'h0000;
      period <= 16'h0000;
    end else begin
      refPrev <= refLvl;
      if (refLvl && !refPrev) halfRef <= !halfRef;
      effPrev <= effRef;
      if (effRise) begin
        period <= cnt + 16'h0001;
        cnt <= 16'h0000;
      end else if (cnt != 16'hFFFF) begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divided clock, counted in reference half periods
  logic [5:0] hc;
  logic alt;
  logic [5:0] hiLen;
  logic [5:0] nextHc;
  always_comb begin
    nextHc = (hc == R - 6'h01) ? 6'h00 : hc + 6'h01;
    if (!R[0]) hiLen = R >> 1;
    else if (SYNTH_BAND == cms_pkg::CMS_HIGH || LOOP_BAND == cms_pkg::CMS_HIGH)
      hiLen = (R - 6'h01) >> 1;
    else hiLen = alt ? (R + 6'h01) >> 1 : (R - 6'h01) >> 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hc <= 6'h00;
      alt <= 1'b0;
      divClkOut <= 1'b0;
    end else if (effEdge) begin
      hc <= nextHc;
      if (nextHc == 6'h00) alt <= !alt;
      divClkOut <= nextHc < hiLen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synthesized clock: toggles 2M times per D reference periods
  logic [22:0] acc;
  wire [22:0] lim = 23'(period) * 23'(D);
  wire [22:0] sum = acc + 23'({M2, 1'b0});
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc <= 23'h000000;
      synthClkOut <= 1'b0;
      synthClkInv <= 1'b1;
    end else if (period != 16'h0000) begin
      if (sum >= lim) begin
        acc <= sum - lim;
        synthClkOut <= !synthClkOut;
        synthClkInv <= synthClkOut;
      end else begin
        acc <= sum;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase outputs: 090/270 regenerated from the measured period, 000/180 too with duty correction, else from the reference
  wire [15:0] halfP = period >> 1;
  wire [15:0] qtrP = period >> 2;
  wire [15:0] cNow = effRise ? 16'h0000 : cnt + 16'h0001;
  wire win = cNow >= qtrP && cNow < halfP + qtrP;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phaseOut000 <= 1'b0;
      phaseOut090 <= 1'b0;
      phaseOut180 <= 1'b1;
      phaseOut270 <= 1'b1;
    end else if (DUTY_CORR) begin
      phaseOut000 <= cNow < halfP;
      phaseOut180 <= !(cNow < halfP);
      phaseOut090 <= win;
      phaseOut270 <= !win;
    end else begin
      phaseOut000 <= effRef;
      phaseOut180 <= !effRef;
      phaseOut090 <= win;
      phaseOut270 <= !win;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock-wait stall
  wire waitOn = HOLD_BOOT && LOCK_PHASE != 3'(cms_pkg::LOCK_NOWAIT);
  always_ff @(posedge clk) begin
    if (!rst_b) bootStall <= 1'b0;
    else bootStall <= waitOn && startupCycle == LOCK_PHASE && !lockLvl;
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave and phase offset
  cms_pkg::cms_phase_t phase;
  wire req = wbReq.cyc && wbReq.stb && !wbAck;
  wire phWr = req && wbReq.we && wbReq.sel[0] && wbReq.adr == cms_pkg::OFS_PHASE;
  wire inc = phWr && wbReq.dat[cms_pkg::PH_INC] && !wbReq.dat[cms_pkg::PH_DEC];
  wire dec = phWr && wbReq.dat[cms_pkg::PH_DEC] && !wbReq.dat[cms_pkg::PH_INC];
  always_ff @(posedge clk) begin
    if (!rst_b) phase <= START;
    else if (STEPS && inc && phase < HI) phase <= phase + 11'sh001;
    else if (STEPS && dec && phase > LO) phase <= phase - 11'sh001;
  end
  logic [31:0] rd;
  always_comb begin
    rd = cms_pkg::WB_ZERO;
    if (wbReq.adr == cms_pkg::OFS_CFG) begin
      rd[2:0] = SHIFT_MODE;
      rd[cms_pkg::CFG_HALVE] = HALVE;
      rd[cms_pkg::CFG_DESKEW] = DESKEW;
      rd[cms_pkg::CFG_SBAND] = SYNTH_BAND;
      rd[cms_pkg::CFG_LBAND] = LOOP_BAND;
      rd[cms_pkg::CFG_DUTY] = DUTY_CORR;
      rd[cms_pkg::CFG_GOAL] = GOAL;
      rd[cms_pkg::CFG_HOLD] = HOLD_BOOT;
      rd[cms_pkg::CFG_LPH +: 3] = LOCK_PHASE;
      rd[cms_pkg::CFG_JIT +: 16] = JITTER_WORD;
    end else if (wbReq.adr == cms_pkg::OFS_RATIO) begin
      rd[5:0] = R;
      rd[cms_pkg::RAT_M +: 6] = M2;
      rd[cms_pkg::RAT_D +: 6] = D;
    end else if (wbReq.adr == cms_pkg::OFS_PHASE) begin
      rd[10:0] = phase;
    end else if (wbReq.adr == cms_pkg::OFS_STATUS) begin
      rd[cms_pkg::ST_LOCK] = lockLvl;
      rd[cms_pkg::ST_STALL] = bootStall;
      rd[cms_pkg::ST_PER +: 16] = period;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wbAck <= 1'b0;
      wbDatOut <= cms_pkg::WB_ZERO;
    end else begin
      wbAck <= req;
      if (req && !wbReq.we) wbDatOut <= rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ackPulse_a: assert property (wbAck |=> !wbAck) else $error("ack held");
  ackReply_a: assert property (req |=> wbAck) else $error("no ack");
  phaseLim_a: assert property (phase >= LO && phase <= HI)
    else $error("phase out of range");
  phaseUp_a: assert property (STEPS && inc && phase < HI |=> phase == $past(phase) + 11'sh001)
    else $error("increment lost");
  phaseHold_a: assert property (!phWr |=> $stable(phase))
    else $error("phase moved");
  stallLock_a: assert property (lockLvl |=> !bootStall)
    else $error("stall while locked");
  stallWait_a: assert property (waitOn && startupCycle == LOCK_PHASE && !lockLvl |=> bootStall)
    else $error("no stall");
  halfTog_a: assert property (refLvl && !refPrev |=> halfRef != $past(halfRef))
    else $error("halving missed");
  divWrap_a: assert property (hc < R)
    else $error("divider overrun");
  synthAcc_a: assert property (period != 16'h0000 && $stable(period) |=> acc < lim + 23'({M2, 1'b0}))
    else $error("accumulator overrun");
  stallSeen_c: cover property (bootStall ##1 !bootStall);
  phaseStep_c: cover property (inc ##[1:20] dec);
  divRise_c: cover property (!divClkOut ##1 divClkOut);
endmodule : cms_static_config

// ---- tb/cms_startup_seq.sv ----
/*
  behavioural model of the configuration startup sequencer that can wait for lock.
  assumes it shares clk and rst_b with the clock manager configuration block.
*/
`timescale 1ns/1ps
module cms_startup_seq #(
  parameter int DWELL = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bootStall,
  output logic [2:0] startupCycle,
  output logic seqDone
);
  logic [3:0] dwell;
  ////////////////////////////////////////////////////////////////////////
  // cycle stepping, held while the block stalls it
  assign seqDone = (startupCycle == 3'h7);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      startupCycle <= 3'h0;
      dwell <= 4'h0;
    end else if (!seqDone) begin
      if (dwell >= 4'(DWELL - 1) && !bootStall) begin
        startupCycle <= startupCycle + 3'h1;
        dwell <= 4'h0;
      end else if (dwell != 4'hF) begin
        dwell <= dwell + 4'h1;
      end
    end
  end
endmodule : cms_startup_seq

// ---- tb/cms_static_config_tb_top.sv ----
/*
  self-checking bench of the clock manager static configuration block.
  assumes the startup sequencer model and the wishbone register map of the package.
*/
`timescale 1ns/1ps
module cms_static_config_tb_top;
  localparam int REF_HALF = 10;
  localparam int RAT2 = 5;
  localparam int SM = 3;
  localparam int SD = 2;
  logic clk, rst_b, refClkIn, lockIn, wbAck, bootStall, seqDone;
  logic divClkOut, synthClkOut, synthClkInv;
  logic phaseOut000, phaseOut090, phaseOut180, phaseOut270;
  logic [31:0] wbDatOut, rd;
  logic [2:0] startupCycle;
  logic [3:0] refCnt;
  cms_pkg::cms_wbreq_s wbReq;
  int fails, checks_done;
  cms_static_config #(.SHIFT_MODE(cms_pkg::CMS_VARCTR), .PHASE_SHIFT(-5), .RATIO2(RAT2),
    .SYNTH_M(SM), .SYNTH_D(SD), .HOLD_BOOT(1'b1), .LOCK_PHASE(3'h3)) cms_static_config_i (
    .clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .refClkIn(refClkIn), .lockIn(lockIn), .startupCycle(startupCycle),
    .bootStall(bootStall), .divClkOut(divClkOut), .synthClkOut(synthClkOut),
    .synthClkInv(synthClkInv), .phaseOut000(phaseOut000), .phaseOut090(phaseOut090),
    .phaseOut180(phaseOut180), .phaseOut270(phaseOut270));
  cms_startup_seq cms_startup_seq_i (.clk(clk), .rst_b(rst_b), .bootStall(bootStall),
    .startupCycle(startupCycle), .seqDone(seqDone));
  ////////////////////////////////////////////////////////////////////////
  // clock and reference clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!rst_b) begin
      refCnt <= 4'h0;
      refClkIn <= 1'b0;
    end else begin
      refCnt <= (refCnt == 4'(REF_HALF - 1)) ? 4'h0 : refCnt + 4'h1;
      if (refCnt == 4'(REF_HALF - 1)) refClkIn <= ~refClkIn;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : check
  task automatic inrange(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      fails++;
    end
  endtask : inrange
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = wbDatOut;
    wbReq <= '0;
    @(posedge clk);
    if (n >= 20) begin
      fails++;
      report_and_stop();
    end
  endtask : wb_xfer
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check(32'({wbAck, bootStall, synthClkInv, phaseOut180, phaseOut270}), 32'h7);
    check(wbDatOut, cms_pkg::WB_ZERO);
    $display("test reset done");
  endtask : t_reset
  task automatic t_readback();
    logic [31:0] e;
    e = (32'(cms_pkg::JITTER_DEF) << cms_pkg::CFG_JIT) | (32'h3 << cms_pkg::CFG_LPH)
      | (32'h1 << cms_pkg::CFG_HOLD) | (32'h1 << cms_pkg::CFG_DUTY) | 32'(cms_pkg::CMS_VARCTR);
    wb_xfer(1'b1, cms_pkg::OFS_CFG, 32'h0, 4'hF, rd);
    wb_xfer(1'b0, cms_pkg::OFS_CFG, 32'h0, 4'hF, rd);
    check(rd, e);
    wb_xfer(1'b0, cms_pkg::OFS_RATIO, 32'h0, 4'hF, rd);
    check(rd, 32'(RAT2) | (32'(SM) << cms_pkg::RAT_M) | (32'(SD) << cms_pkg::RAT_D));
    wb_xfer(1'b0, 8'h10, 32'h0, 4'hF, rd);
    check(rd, cms_pkg::WB_ZERO);
    $display("test readback done");
  endtask : t_readback
  task automatic t_phase();
    logic [31:0] steps [5];
    logic [3:0] sels [5];
    int exp_ph [5];
    steps = '{32'h1, 32'h1, 32'h2, 32'h3, 32'h1};
    sels = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h0};
    exp_ph = '{-4, -3, -4, -4, -4};
    wb_xfer(1'b0, cms_pkg::OFS_PHASE, 32'h0, 4'hF, rd);
    check(rd, {21'h000000, 11'(-5)});
    for (int i = 0; i < 5; i++) begin
      wb_xfer(1'b1, cms_pkg::OFS_PHASE, steps[i], sels[i], rd);
      wb_xfer(1'b0, cms_pkg::OFS_PHASE, 32'h0, 4'hF, rd);
      check(rd, {21'h000000, 11'(exp_ph[i])});
    end
    $display("test phase done");
  endtask : t_phase
  task automatic t_clocks();
    int hd, rdv, rs, h0, h9, hb, inv;
    logic pd, ps;
    hd = 0;
    rdv = 0;
    rs = 0;
    h0 = 0;
    h9 = 0;
    hb = 0;
    inv = 0;
    pd = divClkOut;
    ps = synthClkOut;
    repeat (1000) begin
      @(posedge clk);
      hd += int'(divClkOut);
      rdv += int'(divClkOut && !pd);
      rs += int'(synthClkOut && !ps);
      h0 += int'(phaseOut000);
      h9 += int'(phaseOut090);
      hb += int'(phaseOut000 && phaseOut090);
      if (phaseOut180 !== ~phaseOut000 || phaseOut270 !== ~phaseOut090) inv++;
      if (synthClkInv !== ~synthClkOut) inv++;
      pd = divClkOut;
      ps = synthClkOut;
    end
    inrange(rdv, 1000 / (RAT2 * REF_HALF) - 1, 1000 / (RAT2 * REF_HALF) + 1);
    inrange(hd, 490, 510);
    inrange(rs, 1000 * SM / (SD * 2 * REF_HALF) - 1, 1000 * SM / (SD * 2 * REF_HALF) + 1);
    inrange(h0, 480, 520);
    inrange(h9, 480, 520);
    inrange(hb, 230, 270);
    check(32'(inv), 32'h0);
    $display("test clocks done");
  endtask : t_clocks
  task automatic t_stall();
    int n;
    check(32'({startupCycle, bootStall}), 32'h7);
    wb_xfer(1'b0, cms_pkg::OFS_STATUS, 32'h0, 4'hF, rd);
    check(32'(rd[1:0]), 32'h2);
    inrange(int'(rd[31:16]), 2 * REF_HALF - 1, 2 * REF_HALF + 1);
    lockIn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check(32'(bootStall), 32'h1);
    n = 0;
    while (bootStall !== 1'b0 && n < 10) begin
      @(posedge clk);
      n++;
    end
    inrange(n, 1, 6);
    if (n >= 10) report_and_stop();
    n = 0;
    while (seqDone !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(32'(seqDone), 32'h1);
    if (seqDone !== 1'b1) report_and_stop();
    $display("test stall done");
  endtask : t_stall
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_b = 1'b0;
    lockIn = 1'b0;
    wbReq = '0;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    t_reset();
    rst_b <= 1'b1;
    @(posedge clk);
    t_readback();
    t_phase();
    repeat (200) @(posedge clk);
    t_clocks();
    t_stall();
    report_and_stop();
  end
endmodule : cms_static_config_tb_top
